// ===== verilog/sdtv_filter_ctl_regs.vh
// register map, field positions, reset values and codes for the sd luma/chroma control
// assumes a byte-addressed avalon-mm slave with one aligned 32-bit word per register
`ifndef SDTV_FILTER_CTL_REGS_VH
`define SDTV_FILTER_CTL_REGS_VH

// ********************************************************************
// register byte offsets
// ********************************************************************
`define OFS_FULL_WIN        16'h5e8c
`define OFS_PART_WIN        16'h5e90
`define OFS_RUNIN_WIN       16'h5e94
`define OFS_LUMA_BREAK      16'h5e98
`define OFS_CHROMA_BREAK    16'h5e9c
`define OFS_LUMA_VBI_GAIN   16'h5ea0
`define OFS_CHROMA_GAIN     16'h5ea4
`define OFS_BLANK_PEDESTAL  16'h5ea8
`define OFS_CD_BLANK        16'h5eac
`define OFS_SYNC_TIPS       16'h5eb0
`define OFS_FILTER_CTL      16'h5eb4
`define OFS_OUTPUT_MODE     16'h5f00
`define OFS_LINE_STATUS     16'h5f04

// ********************************************************************
// field positions
// ********************************************************************
`define FLD_LO_LSB          0
`define FLD_HI_LSB          16
`define BIT_LUMA_BREAK      16
`define BIT_U_BREAK         12
`define BIT_V_BREAK         28
`define BIT_FILTER_EN       0
`define FLD_BLEND_LSB       8
`define BIT_BLANK_ON_RB     0
`define BIT_COMPONENT       1

// ********************************************************************
// reset values
// ********************************************************************
`define RST_FULL_WIN        32'h0d14_022f
`define RST_PART_WIN        32'h066d_06a6
`define RST_RUNIN_WIN       32'h0430_01c6
`define RST_LUMA_BREAK      32'h0000_02ff
`define RST_CHROMA_BREAK    32'h01d7_0150
`define RST_LUMA_VBI_GAIN   32'h0100_0100
`define RST_CHROMA_GAIN     32'h0100_0100
`define RST_BLANK_PEDESTAL  32'h00eb_00eb
`define RST_CD_BLANK        32'h0000_00eb
`define RST_SYNC_TIPS       32'h0111_0010
`define RST_FILTER_CTL      32'h0000_0401
`define RST_OUTPUT_MODE     32'h0000_0000

// ********************************************************************
// codes and limits
// ********************************************************************
`define CHROMA_GAIN_MAX     9'h120
`define ALT_COMPOSITE       2'h0
`define ALT_SVIDEO          2'h1
`define ALT_SLEW            2'h2
`define ALT_RAW             2'h3
`define BLEND_QUARTERS      3'h4

`endif

// ===== verilog/sdtv_filter_ctl.v
// luma filter windows, break-point limiting, contrast/saturation gains and
// sync/blank level constants of one sd tv encoder channel
// assumes pixel data, filter outputs and line timing arrive on clk_sys;
// vertical timing (active lines, partial-line flag, vbi lines) comes from outside
`timescale 1ns/1ns

module sdtv_filter_ctl #(
  parameter CNT_W = 12,
  parameter PIX_W = 10
) (
  input  wire              clk_sys,
  input  wire              rstn,
  input  wire [15:0]       avs_address,
  input  wire              avs_read,
  input  wire              avs_write,
  input  wire [31:0]       avs_writedata,
  input  wire [3:0]        avs_byteenable,
  output reg  [31:0]       avs_readdata,
  output wire              avs_waitrequest,
  input  wire              line_start,
  input  wire              line_active,
  input  wire              partial_line,
  input  wire              vbi_line,
  input  wire [PIX_W-1:0]  luma_in,
  input  wire [PIX_W-1:0]  comp_filt,
  input  wire [PIX_W-1:0]  svid_filt,
  input  wire [PIX_W-1:0]  slew_filt,
  input  wire [PIX_W-1:0]  u_in,
  input  wire [PIX_W-1:0]  v_in,
  output reg  [PIX_W-1:0]  luma_out,
  output reg  [PIX_W-1:0]  u_out,
  output reg  [PIX_W-1:0]  v_out,
  output reg               filter_window,
  output reg               runin_window,
  output reg  [8:0]        luma_blank_level,
  output reg  [8:0]        pedestal_level,
  output reg  [8:0]        luma_sync_tip,
  output reg  [8:0]        red_blue_blank_level,
  output reg  [8:0]        colour_difference_sync_tip
);

`include "sdtv_filter_ctl_regs.vh"

  // ********************************************************************
  // helper functions
  // ********************************************************************
  // window is open from first+1 through last inclusive
  function in_window;
    input [CNT_W-1:0] cnt;
    input [CNT_W-1:0] first;
    input [CNT_W-1:0] last;
    begin
      in_window = (cnt > first) && (cnt <= last);
    end
  endfunction
  // halve whatever stands above the limit when the break is on
  function [11:0] break_point;
    input [11:0] val;
    input [11:0] lim;
    input        en;
    reg   [11:0] excess;
    begin
      excess = val - lim;
      if (en && (val > lim)) begin
        break_point = lim + {1'b0, excess[11:1]};
      end else begin
        break_point = val;
      end
    end
  endfunction
  // 10-bit sample times unsigned 1.8 gain, fraction dropped
  function [11:0] apply_gain;
    input [PIX_W-1:0] val;
    input [8:0]       gain;
    reg   [18:0]      prod;
    begin
      prod       = val * gain;
      apply_gain = {1'b0, prod[18:8]};
    end
  endfunction
  // clip to the dac code range
  function [PIX_W-1:0] sat;
    input [11:0] val;
    begin
      if (val > 12'h03ff) begin
        sat = 10'h3ff;
      end else begin
        sat = val[PIX_W-1:0];
      end
    end
  endfunction
  // byte-lane merge of a write into a stored word
  function [31:0] merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0]  be;
    integer      i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          merge[i*8 +: 8] = wd[i*8 +: 8];
        end
      end
    end
  endfunction

  // ********************************************************************
  // register storage
  // ********************************************************************
  reg [31:0] full_width_filter_window;
  reg [31:0] partial_width_filter_window;
  reg [31:0] runin_filter_window;
  reg [31:0] luma_break_point;
  reg [31:0] chroma_break_points;
  reg [31:0] luma_and_vbi_gain;
  reg [31:0] chroma_gains;
  reg [31:0] luma_blank_and_pedestal;
  reg [31:0] colour_difference_blank;
  reg [31:0] sync_tip_levels;
  reg [31:0] luma_filter_control;
  reg [31:0] output_mode;
  reg        bus_ack;
  reg [CNT_W-1:0] pix_cnt;

  // field views
  wire [CNT_W-1:0] full_filter_first_pixel    = full_width_filter_window[11:0];
  wire [CNT_W-1:0] full_filter_last_pixel     = full_width_filter_window[27:16];
  wire [CNT_W-1:0] partial_filter_first_pixel = partial_width_filter_window[11:0];
  wire [CNT_W-1:0] partial_filter_last_pixel  = partial_width_filter_window[27:16];
  wire [CNT_W-1:0] runin_first_pixel          = runin_filter_window[11:0];
  wire [CNT_W-1:0] runin_last_pixel           = runin_filter_window[27:16];
  wire [10:0] luma_limit        = luma_break_point[10:0];
  wire        luma_break_enable = luma_break_point[`BIT_LUMA_BREAK];
  wire [9:0]  u_limit           = chroma_break_points[9:0];
  wire        u_break_enable    = chroma_break_points[`BIT_U_BREAK];
  wire [9:0]  v_limit           = chroma_break_points[25:16];
  wire        v_break_enable    = chroma_break_points[`BIT_V_BREAK];
  wire [8:0]  luma_gain         = luma_and_vbi_gain[8:0];
  wire [8:0]  vbi_gain          = luma_and_vbi_gain[24:16];
  wire [8:0]  u_gain            = chroma_gains[8:0];
  wire [8:0]  v_gain            = chroma_gains[24:16];
  wire        luma_filter_enable = luma_filter_control[`BIT_FILTER_EN];
  wire [3:0]  composite_sharpness_blend = luma_filter_control[11:8];
  wire        blank_on_red_blue_select  = output_mode[`BIT_BLANK_ON_RB];
  wire        component_mode            = output_mode[`BIT_COMPONENT];

  // ********************************************************************
  // avalon-mm slave
  // ********************************************************************
  // one wait cycle per access: read data is a flop, valid when waitrequest drops
  assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack;

  always @(posedge clk_sys) begin
    if (!rstn) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= (avs_read | avs_write) & ~bus_ack;
    end
  end

  // read mux, loaded in the wait cycle; unmapped addresses read zero
  always @(posedge clk_sys) begin
    if (!rstn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !bus_ack) begin
      if (avs_address == `OFS_FULL_WIN) begin
        avs_readdata <= {4'h0, full_width_filter_window[27:16], 4'h0,
                         full_width_filter_window[11:0]};
      end else if (avs_address == `OFS_PART_WIN) begin
        avs_readdata <= {4'h0, partial_width_filter_window[27:16], 4'h0,
                         partial_width_filter_window[11:0]};
      end else if (avs_address == `OFS_RUNIN_WIN) begin
        avs_readdata <= {4'h0, runin_filter_window[27:16], 4'h0,
                         runin_filter_window[11:0]};
      end else if (avs_address == `OFS_LUMA_BREAK) begin
        avs_readdata <= {15'h0000, luma_break_enable, 5'h00, luma_limit};
      end else if (avs_address == `OFS_CHROMA_BREAK) begin
        avs_readdata <= {3'h0, v_break_enable, 2'h0, v_limit, 3'h0,
                         u_break_enable, 2'h0, u_limit};
      end else if (avs_address == `OFS_LUMA_VBI_GAIN) begin
        avs_readdata <= {7'h00, vbi_gain, 7'h00, luma_gain};
      end else if (avs_address == `OFS_CHROMA_GAIN) begin
        avs_readdata <= {7'h00, v_gain, 7'h00, u_gain};
      end else if (avs_address == `OFS_BLANK_PEDESTAL) begin
        avs_readdata <= {7'h00, luma_blank_and_pedestal[24:16], 7'h00,
                         luma_blank_and_pedestal[8:0]};
      end else if (avs_address == `OFS_CD_BLANK) begin
        avs_readdata <= {23'h00_0000, colour_difference_blank[8:0]};
      end else if (avs_address == `OFS_SYNC_TIPS) begin
        avs_readdata <= {7'h00, sync_tip_levels[24:16], 7'h00, sync_tip_levels[8:0]};
      end else if (avs_address == `OFS_FILTER_CTL) begin
        avs_readdata <= {20'h0_0000, composite_sharpness_blend, 7'h00,
                         luma_filter_enable};
      end else if (avs_address == `OFS_OUTPUT_MODE) begin
        avs_readdata <= {30'h0000_0000, component_mode, blank_on_red_blue_select};
      end else if (avs_address == `OFS_LINE_STATUS) begin
        avs_readdata <= {14'h0000, runin_window, filter_window, 4'h0, pix_cnt};
      end else begin
        avs_readdata <= 32'h0000_0000;
      end
    end
  end

  // writes land on the edge where waitrequest is low
  always @(posedge clk_sys) begin
    if (!rstn) begin
      full_width_filter_window    <= `RST_FULL_WIN;
      partial_width_filter_window <= `RST_PART_WIN;
      runin_filter_window         <= `RST_RUNIN_WIN;
      luma_break_point            <= `RST_LUMA_BREAK;
      chroma_break_points         <= `RST_CHROMA_BREAK;
      luma_and_vbi_gain           <= `RST_LUMA_VBI_GAIN;
      chroma_gains                <= `RST_CHROMA_GAIN;
      luma_blank_and_pedestal     <= `RST_BLANK_PEDESTAL;
      colour_difference_blank     <= `RST_CD_BLANK;
      sync_tip_levels             <= `RST_SYNC_TIPS;
      luma_filter_control         <= `RST_FILTER_CTL;
      output_mode                 <= `RST_OUTPUT_MODE;
    end else if (avs_write && bus_ack) begin
      if (avs_address == `OFS_FULL_WIN) begin
        full_width_filter_window <= merge(full_width_filter_window, avs_writedata,
                                          avs_byteenable);
      end else if (avs_address == `OFS_PART_WIN) begin
        partial_width_filter_window <= merge(partial_width_filter_window, avs_writedata,
                                             avs_byteenable);
      end else if (avs_address == `OFS_RUNIN_WIN) begin
        runin_filter_window <= merge(runin_filter_window, avs_writedata, avs_byteenable);
      end else if (avs_address == `OFS_LUMA_BREAK) begin
        luma_break_point <= merge(luma_break_point, avs_writedata, avs_byteenable);
      end else if (avs_address == `OFS_CHROMA_BREAK) begin
        chroma_break_points <= merge(chroma_break_points, avs_writedata, avs_byteenable);
      end else if (avs_address == `OFS_LUMA_VBI_GAIN) begin
        luma_and_vbi_gain <= merge(luma_and_vbi_gain, avs_writedata, avs_byteenable);
      end else if (avs_address == `OFS_CHROMA_GAIN) begin
        chroma_gains <= merge(chroma_gains, avs_writedata, avs_byteenable);
      end else if (avs_address == `OFS_BLANK_PEDESTAL) begin
        luma_blank_and_pedestal <= merge(luma_blank_and_pedestal, avs_writedata,
                                         avs_byteenable);
      end else if (avs_address == `OFS_CD_BLANK) begin
        colour_difference_blank <= merge(colour_difference_blank, avs_writedata,
                                         avs_byteenable);
      end else if (avs_address == `OFS_SYNC_TIPS) begin
        sync_tip_levels <= merge(sync_tip_levels, avs_writedata, avs_byteenable);
      end else if (avs_address == `OFS_FILTER_CTL) begin
        luma_filter_control <= merge(luma_filter_control, avs_writedata, avs_byteenable);
      end else if (avs_address == `OFS_OUTPUT_MODE) begin
        output_mode <= merge(output_mode, avs_writedata, avs_byteenable);
      end
    end
  end

  // ********************************************************************
  // line counter and windows
  // ********************************************************************
  // counter saturates so a missing line start never wraps into a window
  always @(posedge clk_sys) begin
    if (!rstn) begin
      pix_cnt <= {CNT_W{1'b0}};
    end else if (line_start) begin
      pix_cnt <= {CNT_W{1'b0}};
    end else if (pix_cnt != {CNT_W{1'b1}}) begin
      pix_cnt <= pix_cnt + 1'b1;
    end
  end

  // window decode; partial_line is the vertical start/end lsb from the line timer
  wire full_hit    = in_window(pix_cnt, full_filter_first_pixel,
                               full_filter_last_pixel);
  wire partial_hit = in_window(pix_cnt, partial_filter_first_pixel,
                               partial_filter_last_pixel);
  wire runin_hit   = in_window(pix_cnt, runin_first_pixel, runin_last_pixel);
  wire next_filter_window = line_active && (partial_line ? partial_hit : full_hit);
  wire next_runin_window  = vbi_line && runin_hit;

  // ********************************************************************
  // luma blend, gain and break
  // ********************************************************************
  reg [PIX_W-1:0] alt_filt;
  reg [2:0]       alt_quarters;
  reg [12:0]      blend_sum;
  reg [PIX_W-1:0] filtered;
  reg [11:0]      luma_gained;

  // alternate filter and its weight, composite filter takes the remainder
  always @* begin
    case (composite_sharpness_blend[3:2])
      `ALT_COMPOSITE: alt_filt = comp_filt;
      `ALT_SVIDEO:    alt_filt = svid_filt;
      `ALT_SLEW:      alt_filt = slew_filt;
      default:        alt_filt = luma_in;
    endcase
    alt_quarters = `BLEND_QUARTERS - {1'b0, composite_sharpness_blend[1:0]};
    blend_sum = alt_filt * alt_quarters + comp_filt * (`BLEND_QUARTERS - alt_quarters);
    if (luma_filter_enable && next_filter_window) begin
      filtered = blend_sum[PIX_W+1:2];
    end else begin
      filtered = luma_in;
    end
  end

  // vbi lines use their own gain, the run-in stretch passes untouched
  always @* begin
    if (next_runin_window) begin
      luma_gained = {2'b00, luma_in};
    end else if (vbi_line) begin
      luma_gained = apply_gain(luma_in, vbi_gain);
    end else begin
      luma_gained = apply_gain(filtered, luma_gain);
    end
  end

  // saturation gains clamp at 1.125
  wire [8:0] u_gain_eff = (u_gain > `CHROMA_GAIN_MAX) ? `CHROMA_GAIN_MAX : u_gain;
  wire [8:0] v_gain_eff = (v_gain > `CHROMA_GAIN_MAX) ? `CHROMA_GAIN_MAX : v_gain;

  // one registered stage from pixel in to pixel out
  always @(posedge clk_sys) begin
    if (!rstn) begin
      luma_out      <= {PIX_W{1'b0}};
      u_out         <= {PIX_W{1'b0}};
      v_out         <= {PIX_W{1'b0}};
      filter_window <= 1'b0;
      runin_window  <= 1'b0;
    end else begin
      filter_window <= next_filter_window;
      runin_window  <= next_runin_window;
      if (next_runin_window) begin
        luma_out <= luma_in;
      end else begin
        luma_out <= sat(break_point(luma_gained, {1'b0, luma_limit},
                                    luma_break_enable));
      end
      u_out <= sat(break_point(apply_gain(u_in, u_gain_eff), {2'b00, u_limit},
                               u_break_enable));
      v_out <= sat(break_point(apply_gain(v_in, v_gain_eff), {2'b00, v_limit},
                               v_break_enable));
    end
  end

  // ********************************************************************
  // level constants toward the output stage
  // ********************************************************************
  // levels are taken as programmed; software owns their consistency
  always @(posedge clk_sys) begin
    if (!rstn) begin
      luma_blank_level           <= 9'h000;
      pedestal_level             <= 9'h000;
      luma_sync_tip              <= 9'h000;
      red_blue_blank_level       <= 9'h000;
      colour_difference_sync_tip <= 9'h000;
    end else begin
      luma_blank_level           <= luma_blank_and_pedestal[8:0];
      pedestal_level             <= luma_blank_and_pedestal[24:16];
      luma_sync_tip              <= sync_tip_levels[8:0];
      colour_difference_sync_tip <= sync_tip_levels[24:16];
      if (blank_on_red_blue_select || component_mode) begin
        red_blue_blank_level <= colour_difference_blank[8:0];
      end else begin
        red_blue_blank_level <= luma_blank_and_pedestal[8:0];
      end
    end
  end

endmodule // sdtv_filter_ctl

// ===== test/sdtv_filter_ctl_checker.sv
// checker: port timing relations of sdtv_filter_ctl
// assumes bind onto the design, one clock, synchronous active-low reset
`timescale 1ns/1ns
module sdtv_filter_ctl_checker #(
  parameter PIX_W = 10
) (
  input wire             clk_sys,
  input wire             rstn,
  input wire             avs_read,
  input wire             avs_write,
  input wire [31:0]      avs_readdata,
  input wire             avs_waitrequest,
  input wire             line_start,
  input wire             line_active,
  input wire             vbi_line,
  input wire [PIX_W-1:0] luma_in,
  input wire [PIX_W-1:0] luma_out,
  input wire             filter_window,
  input wire             runin_window,
  input wire [8:0]       luma_sync_tip,
  input wire [8:0]       red_blue_blank_level
);
  // ******************************
  // properties
  // ******************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_wait_one: assert property ($rose(avs_read) || $rose(avs_write) |->
    avs_waitrequest ##1 !avs_waitrequest) else $error("bus wait not one cycle");
  a_wait_idle: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
    else $error("wait raised while idle");
  a_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved without a read");
  a_runin_pass: assert property (runin_window |-> luma_out == $past(luma_in))
    else $error("run-in sample altered");
  a_runin_vbi: assert property (runin_window |-> $past(vbi_line))
    else $error("run-in open off a vbi line");
  a_filt_line: assert property (filter_window |-> $past(line_active))
    else $error("filter open off an active line");
  a_line_head: assert property (line_start |-> ##2 !filter_window && !runin_window)
    else $error("window open at count zero");
  // level copies only move after a register write, once reset has settled
  a_levels_hold: assert property ($past(rstn, 2) && !avs_write ##1 !avs_write |=>
    $stable(red_blue_blank_level) && $stable(luma_sync_tip)) else $error("level moved");
  c_runin: cover property (runin_window);
  c_filter: cover property (filter_window);
  c_read: cover property ($fell(avs_waitrequest) && avs_read);
endmodule // sdtv_filter_ctl_checker
bind sdtv_filter_ctl sdtv_filter_ctl_checker #(.PIX_W(PIX_W)) i_sdtv_filter_ctl_checker (
  .clk_sys(clk_sys), .rstn(rstn), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .line_start(line_start),
  .line_active(line_active), .vbi_line(vbi_line), .luma_in(luma_in), .luma_out(luma_out),
  .filter_window(filter_window), .runin_window(runin_window), .luma_sync_tip(luma_sync_tip),
  .red_blue_blank_level(red_blue_blank_level));

// ===== test/tv_dac_model.sv
// behavioural triple video dac fed by the block's pixel outputs
// assumes codes are taken at the rising edge of the pixel clock
`timescale 1ns/1ns
module tv_dac_model (
  input  wire        clk_sys,
  input  wire [9:0]  luma_code,
  input  wire [9:0]  u_code,
  input  wire [9:0]  v_code,
  output reg  [29:0] held_codes
);
  // ******************************
  // converter latch
  // ******************************
  // a real converter registers its input, so one edge of delay
  always @(posedge clk_sys) begin
    held_codes <= {luma_code, u_code, v_code};
  end
endmodule // tv_dac_model

// ===== test/sdtv_filter_ctl_bench.sv
// bench: register, window, blend and gain scenarios for sdtv_filter_ctl
// assumes the register header is on the include path
`timescale 1ns/1ns
`include "sdtv_filter_ctl_regs.vh"
module sdtv_filter_ctl_bench;
  // ******************************
  // stimulus, instances, shared tasks
  // ******************************
  reg         clk_sys = 0;
  reg         rstn = 0;
  reg  [15:0] avs_address = 0;
  reg         avs_read = 0;
  reg         avs_write = 0;
  reg  [31:0] avs_writedata = 0;
  reg  [9:0]  luma_in = 0;
  reg  [9:0]  u_in = 0;
  reg  [9:0]  v_in = 0;
  reg         line_start = 0;
  reg         line_active = 0;
  reg         partial_line = 0;
  reg         vbi_line = 0;
  wire [3:0]  avs_byteenable = 4'hf;
  wire [9:0]  comp_filt = 10'h064;
  wire [9:0]  svid_filt = 10'h0c8;
  wire [9:0]  slew_filt = 10'h12c;
  wire [31:0] avs_readdata;
  wire        avs_waitrequest, filter_window, runin_window;
  wire [9:0]  luma_out, u_out, v_out;
  wire [8:0]  luma_blank_level, pedestal_level, luma_sync_tip;
  wire [8:0]  red_blue_blank_level, colour_difference_sync_tip;
  wire [29:0] held_codes;
  int         miscompares = 0;
  int         num_checks = 0;
  int         nf, nr, q;
  int         alt[4] = '{100, 200, 300, 400};
  reg  [9:0]  wluma;
  reg  [31:0] rdat;
  sdtv_filter_ctl i_sdtv_filter_ctl (.clk_sys(clk_sys), .rstn(rstn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .line_start(line_start), .line_active(line_active), .partial_line(partial_line),
    .vbi_line(vbi_line), .luma_in(luma_in), .comp_filt(comp_filt), .svid_filt(svid_filt),
    .slew_filt(slew_filt), .u_in(u_in), .v_in(v_in), .luma_out(luma_out), .u_out(u_out),
    .v_out(v_out), .filter_window(filter_window), .runin_window(runin_window),
    .luma_blank_level(luma_blank_level), .pedestal_level(pedestal_level),
    .luma_sync_tip(luma_sync_tip), .red_blue_blank_level(red_blue_blank_level),
    .colour_difference_sync_tip(colour_difference_sync_tip));
  tv_dac_model i_tv_dac_model (.clk_sys(clk_sys), .luma_code(luma_out), .u_code(u_out),
    .v_code(v_out), .held_codes(held_codes));
  // 20 mhz pixel clock
  always #25 clk_sys = ~clk_sys;
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // request held until waitrequest is seen low at an edge
  task bus(input wr, input [15:0] a, input [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rdat = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
  endtask
  // one line: count open samples, keep luma seen inside the filter window
  task run_line();
    nf = 0;
    nr = 0;
    @(posedge clk_sys) line_start <= 1;
    @(posedge clk_sys) line_start <= 0;
    repeat (24) begin
      @(posedge clk_sys);
      #1;
      nf += (filter_window === 1'b1);
      nr += (runin_window === 1'b1);
      if (filter_window === 1'b1) wluma = luma_out;
    end
    // hand back on an edge so callers drive inputs there
    @(posedge clk_sys);
  endtask
  // ******************************
  // scenarios
  // ******************************
  task t_reset();
    bus(0, `OFS_FULL_WIN, 0);
    chk("full_win", rdat, `RST_FULL_WIN);
    bus(0, `OFS_FILTER_CTL, 0);
    chk("filter_ctl", rdat, `RST_FILTER_CTL);
    bus(0, `OFS_CHROMA_BREAK, 0);
    chk("chroma_break", rdat, `RST_CHROMA_BREAK);
    bus(0, 16'h5e00, 0);
    chk("unmapped", rdat, 0);
    chk("rb_blank", red_blue_blank_level, 9'h0eb);
  endtask
  task t_windows();
    luma_in <= 10'h190;
    line_active <= 1;
    bus(1, `OFS_FULL_WIN, 32'h0008_0005);
    bus(1, `OFS_PART_WIN, 32'h000c_000a);
    run_line();
    chk("full_span", nf, 3);
    partial_line <= 1;
    run_line();
    chk("part_span", nf, 2);
    line_active <= 0;
    vbi_line <= 1;
    bus(1, `OFS_RUNIN_WIN, 32'h0004_0001);
    run_line();
    chk("runin_span", nr, 3);
    chk("dead_span", nf, 0);
    vbi_line <= 0;
    line_active <= 1;
    partial_line <= 0;
  endtask
  // every alternate filter at every weight, composite as base
  task t_blend();
    for (int b = 0; b < 16; b++) begin
      bus(1, `OFS_FILTER_CTL, {20'h0, b[3:0], 8'h01});
      run_line();
      q = 4 - b % 4;
      chk("blend", wluma, (alt[b / 4] * q + 100 * (4 - q)) >> 2);
    end
    bus(1, `OFS_FILTER_CTL, 32'h0000_0400);
    run_line();
    chk("bypass", wluma, 400);
  endtask
  task t_gain();
    u_in <= 10'h12c;
    v_in <= 10'h12c;
    bus(1, `OFS_LUMA_VBI_GAIN, 32'h0100_0133);
    bus(1, `OFS_LUMA_BREAK, 32'h0001_0100);
    bus(1, `OFS_CHROMA_GAIN, 32'h0080_01ff);
    bus(1, `OFS_CHROMA_BREAK, 32'h117f_1100);
    run_line();
    chk("luma_break", wluma, 367);
    chk("u_out", u_out, 296);
    chk("v_out", v_out, 150);
    chk("dac_uv", held_codes[19:0], {10'd296, 10'd150});
    bus(1, `OFS_LUMA_BREAK, 32'h0000_0100);
    vbi_line <= 1;
    run_line();
    chk("vbi_gain", wluma, 400);
  endtask
  // levels as software sets them: tip 16, height 219, ntsc pedestal, mid-scale pb/pr
  task t_levels();
    bus(1, `OFS_SYNC_TIPS, 32'h0125_0010);
    bus(1, `OFS_BLANK_PEDESTAL, 32'h0115_00eb);
    bus(1, `OFS_CD_BLANK, 32'h0000_0200);
    for (int m = 2; m >= 0; m--) begin
      bus(1, `OFS_OUTPUT_MODE, m);
      repeat (2) @(posedge clk_sys);
      chk("rb_blank", red_blue_blank_level, m ? 9'h200 : 9'h0eb);
    end
    chk("blank", luma_blank_level, 9'h0eb);
    chk("pedestal", pedestal_level, 9'h115);
    chk("sync_tip", luma_sync_tip, 9'h010);
    chk("cd_sync_tip", colour_difference_sync_tip, 9'h125);
  endtask
  task conclude();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // main sequence after six reset cycles
  initial begin
    repeat (6) @(posedge clk_sys);
    rstn <= 1;
    t_reset();
    t_windows();
    t_blend();
    t_gain();
    t_levels();
    conclude();
  end
  // watchdog well past the roughly 700 cycles the run needs
  initial begin
    #500000;
    miscompares++;
    conclude();
  end
endmodule // sdtv_filter_ctl_bench
